// *** inc/wdsv_pkg.sv ***
// package: register map, field layout, reset values and timing constants of the watchdog service block
package wdsv_pkg;
  // register byte offsets (chosen; no offsets printed)
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_VECTOR = 8'h04;
  localparam logic [7:0] OFF_SERVICE = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_COUNT = 8'h14;
  // control field positions
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_SELECT_BIT = 6;
  localparam int CTL_PRESCALE_BIT = 5;
  localparam int CTL_DELAY_LSB = 3;
  // status bit positions
  localparam int ST_TIMEOUT_BIT = 0;
  localparam int ST_SERVICE_BIT = 1;
  localparam int ST_BADKEY_BIT = 2;
  localparam int ST_WIDTH = 3;
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] VECTOR_RESET = 8'h0F;
  localparam logic [ST_WIDTH-1:0] MASK_RESET = 3'h0;
  // service keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // timing: base exponents per delay code, prescale divide
  localparam int DELAY_EXP_BASE = 9;
  localparam int DELAY_EXP_STEP = 2;
  localparam int PRESCALE_DIV = 8192;
  localparam int COUNT_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum {WDSV_IDLE, WDSV_ARMED} wdsv_key_t;
endpackage : wdsv_pkg

// *** inc/wdsv_tick_if.sv ***
// interface: divider enable pulse between the main block and its prescaler
`timescale 1ns/1ps
`default_nettype none
interface wdsv_tick_if;
  logic prescale; // select divide-by-8192
  logic clear; // restart divider phase
  logic tick; // one-cycle count enable
  modport src (input prescale, input clear, output tick);
  modport dst (output prescale, output clear, input tick);
endinterface : wdsv_tick_if
`default_nettype wire

// *** tb/wdsv_core_model.sv ***
// partner: processor core running interrupt-acknowledge cycles
`timescale 1ns/1ps
`default_nettype none
module wdsv_core_model (
  input wire logic aclk, // clock
  input wire logic go, // start one acknowledge
  input wire logic [2:0] lvl, // level to acknowledge
  input wire logic iack_claim, // block answers
  input wire logic [7:0] iack_vector, // returned vector
  input wire logic iack_autovector, // autovector request
  output logic iack_valid, // acknowledge cycle
  output logic [2:0] iack_level, // level acknowledged
  output logic hit, // claim seen
  output logic [7:0] vec, // vector seen
  output logic auto_seen // autovector seen
);
  // one-cycle acknowledge; the answer is taken at the edge that ends the cycle,
  // and the level line shows its inverse once released so nothing stale remains
  initial begin
    iack_valid = 1'b0;
    iack_level = 3'h0;
    hit = 1'b0;
    vec = 8'h00;
    auto_seen = 1'b0;
    forever begin
      @(posedge aclk);
      if (iack_valid) begin
        hit <= iack_claim;
        vec <= iack_vector;
        auto_seen <= iack_autovector;
      end
      if (go) begin
        iack_valid <= 1'b1;
        iack_level <= lvl;
      end else if (iack_valid) begin
        iack_valid <= 1'b0;
        iack_level <= ~iack_level;
      end
    end
  end
endmodule : wdsv_core_model
`default_nettype wire

// *** tb/wdsv_top_monitor.sv ***
// checker: acknowledge, level and soft reset relations at the block ports
`timescale 1ns/1ps
`default_nettype none
module wdsv_top_monitor (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic [2:0] irq_level_cfg, // programmed level
  input wire logic iack_valid, // acknowledge cycle
  input wire logic [2:0] iack_level, // level acknowledged
  input wire logic iack_claim, // block answers
  input wire logic [7:0] iack_vector, // returned vector
  input wire logic iack_autovector, // autovector request
  input wire logic [2:0] wd_irq_level, // level to core
  input wire logic soft_reset // soft reset pulse
);
  import wdsv_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a timeout is pending, and the core acknowledges its level
  sequence s_pend;
    wd_irq_level != 3'h0;
  endsequence
  sequence s_ack;
    iack_valid && iack_level == irq_level_cfg;
  endsequence
  property p_claim;
    s_pend ##0 s_ack |-> iack_claim;
  endproperty
  a_claim: assert property (p_claim) else $error("acknowledge not claimed");
  property p_claim_cause;
    iack_claim |-> iack_valid && iack_level == irq_level_cfg && wd_irq_level == irq_level_cfg;
  endproperty
  a_claim_cause: assert property (p_claim_cause) else $error("claim without pending ack");
  property p_vec_rst;
    $rose(aresetn) |-> iack_vector == VECTOR_RESET;
  endproperty
  a_vec_rst: assert property (p_vec_rst) else $error("vector not reset");
  property p_no_auto;
    iack_autovector == 1'b0;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("autovector raised");
  property p_hold;
    s_pend ##0 !iack_claim |=> s_pend;
  endproperty
  a_hold: assert property (p_hold) else $error("pending dropped without ack");
  property p_ack_clr;
    iack_claim |=> wd_irq_level == 3'h0;
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("pending kept after ack");
  property p_level;
    s_pend |-> wd_irq_level == irq_level_cfg;
  endproperty
  a_level: assert property (p_level) else $error("wrong interrupt level");
  property p_sr;
    soft_reset |-> wd_irq_level == 3'h0 ##1 !soft_reset;
  endproperty
  a_sr: assert property (p_sr) else $error("soft reset not a lone pulse");
  property p_rst_quiet;
    $rose(aresetn) |-> wd_irq_level == 3'h0 && !soft_reset;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("watchdog active after reset");
endmodule : wdsv_top_monitor
bind wdsv_top wdsv_top_monitor u_mon (.aclk, .aresetn, .irq_level_cfg, .iack_valid, .iack_level,
  .iack_claim, .iack_vector, .iack_autovector, .wd_irq_level, .soft_reset);
`default_nettype wire

// *** tb/wdsv_top_tb.sv ***
// testbench: register, service, timeout and acknowledge sequences
`timescale 1ns/1ps
`default_nettype none
module wdsv_top_tb;
  import wdsv_pkg::*;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, go;
  logic awready, wready, bvalid, arready, rvalid, iv, claim, auto, sr, irq, hit, auto_seen;
  logic [7:0] awaddr, araddr, vector, vec;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [2:0] cfg, lvl, il, level;
  logic [1:0] bresp, rresp, resp;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  wdsv_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_level_cfg(cfg),
    .iack_valid(iv), .iack_level(il), .iack_claim(claim), .iack_vector(vector),
    .iack_autovector(auto), .wd_irq_level(level), .soft_reset(sr), .irq(irq));
  wdsv_core_model core (.aclk(aclk), .go(go), .lvl(lvl), .iack_claim(claim), .iack_vector(vector),
    .iack_autovector(auto), .iack_valid(iv), .iack_level(il), .hit(hit), .vec(vec), .auto_seen(auto_seen));
  initial forever #12.5 aclk = ~aclk;
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // a hung handshake ends the run here
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // handshakes are judged mid-cycle, acted on by the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      rv = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic svc;
    wr(OFF_SERVICE, 32'(KEY_FIRST));
    wr(OFF_SERVICE, 32'(KEY_SECOND));
  endtask : svc
  task automatic ack(input logic [2:0] l);
    go <= 1'b1;
    lvl <= l;
    @(posedge aclk);
    go <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : ack
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go} = 7'h00;
    {awaddr, araddr, wdata, wstrb, lvl} = '0;
    cfg = 3'h5;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_CONTROL);
    chk(rv, 32'h0000_0000);
    rd(OFF_VECTOR);
    chk(rv, 32'h0000_000F);
    rd(8'h40);
    chk(32'(resp), 32'h0000_0002);
    wr(8'h44, 32'h0000_00FF);
    chk(32'(resp), 32'h0000_0002);
    wr(OFF_VECTOR, 32'h0000_0042);
    rd(OFF_VECTOR);
    chk(rv, 32'h0000_0042);
    wr(OFF_CONTROL, 32'h0000_0080);
    svc;
    // services with other traffic and a repeated first key between the two keys
    for (int i = 0; i < 3; i++) begin
      repeat (300) @(posedge aclk);
      wr(OFF_SERVICE, 32'(KEY_FIRST));
      rd(OFF_VECTOR);
      svc;
    end
    chk(32'(level), 32'h0000_0000);
    rd(OFF_STATUS);
    chk(rv, 32'h0000_0002);
    // a lone second key must not restart: timeout lands 512 clocks after the last service
    repeat (300) @(posedge aclk);
    wr(OFF_SERVICE, 32'(KEY_SECOND));
    repeat (180) @(posedge aclk);
    chk(32'(level), 32'h0000_0000);
    repeat (40) @(posedge aclk);
    chk(32'(level), 32'h0000_0005);
    rd(OFF_STATUS);
    chk(rv, 32'h0000_000F);
    wr(OFF_CONTROL, 32'h0000_0000);
    rd(OFF_CONTROL);
    chk(rv, 32'h0000_0080);
    svc;
    chk(32'(level), 32'h0000_0005);
    wr(OFF_MASK, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    wr(OFF_STATUS, 32'h0000_0007);
    chk(32'(irq), 32'h0000_0000);
    rd(OFF_STATUS);
    chk(rv, 32'h0000_0008);
    ack(3'h3);
    chk(32'(hit), 32'h0000_0000);
    ack(3'h5);
    chk(32'(hit), 32'h0000_0001);
    chk(32'(vec), 32'h0000_0042);
    chk(32'(auto_seen), 32'h0000_0000);
    chk(32'(level), 32'h0000_0000);
    wr(OFF_CONTROL, 32'h0000_00C0);
    rd(OFF_CONTROL);
    chk(rv, 32'h0000_00C0);
    svc;
    n = 0;
    while (sr !== 1'b1 && n < 600) begin
      @(negedge aclk);
      n++;
    end
    chk(32'(n inside {[490:530]}), 32'h0000_0001);
    chk(32'(level), 32'h0000_0000);
    // next delay code: 2^11 clocks from the service to the soft reset pulse
    @(posedge aclk);
    wr(OFF_CONTROL, 32'h0000_00C8);
    svc;
    n = 0;
    while (sr !== 1'b1 && n < 2200) begin
      @(negedge aclk);
      n++;
    end
    chk(32'(n inside {[2030:2060]}), 32'h0000_0001);
    // a second reset in mid-run brings back the reset values
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_VECTOR);
    chk(rv, 32'h0000_000F);
    rd(OFF_CONTROL);
    chk(rv, 32'h0000_0000);
    tally_and_finish;
  end
endmodule : wdsv_top_tb
`default_nettype wire

// *** verilog/wdsv_prescaler.sv ***
// module: clock-enable divider for the watchdog countdown
`timescale 1ns/1ps
`default_nettype none
module wdsv_prescaler #(
  parameter int DIV = wdsv_pkg::PRESCALE_DIV
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  wdsv_tick_if.src tk // tick carrier
);
  import wdsv_pkg::*;
  localparam int DIV_W = $clog2(DIV);
  logic [DIV_W-1:0] div_reg;
  // free divider; restarts on clear so a service gives a full period
  always_ff @(posedge aclk) begin
    if (!aresetn || tk.clear) begin
      div_reg <= '0;
    end else if (div_reg == DIV_W'(DIV - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  // prescale clear passes every clock, set passes one in DIV
  assign tk.tick = tk.prescale ? (div_reg == DIV_W'(DIV - 1)) : 1'b1; // [R8]
endmodule : wdsv_prescaler
`default_nettype wire

// *** verilog/wdsv_top.sv ***
// module: watchdog vector, service sequence and timeout logic with an AXI4-Lite slave
//
// Contract
// R1: hold an 8-bit vector, drive it during acknowledge of the timeout interrupt.
// R2: system reset loads the vector register with 0x0F.
// R3: the timeout interrupt always supplies the vector, never an autovector answer.
// R4: writing 0x55 then 0xAA to the service register restarts the countdown.
// R5: anything may come between the two service writes, before timeout.
// R6: a service write after timeout leaves the pending flag set.
// R7: acknowledge of the timeout interrupt clears the pending flag by itself.
// R8: period from delay field and prescale: 2^9..2^15 clocks, or times 8192.
// R9: select bit chooses interrupt at programmed level or soft reset on timeout.
// R10: reset leaves the watchdog disabled with the shortest period selected.
// R11: control writes are ignored while timeout pending; reads always allowed.
// R12: wrong service values or a lone 0xAA do not restart the countdown.
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module wdsv_top (
  input wire logic aclk, // system clock, 40 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read response valid
  input wire logic s_axi_rready, // read response ready
  input wire logic [2:0] irq_level_cfg, // level at which the timeout is raised
  input wire logic iack_valid, // core runs an acknowledge cycle
  input wire logic [2:0] iack_level, // level being acknowledged
  output logic iack_claim, // this block answers the acknowledge
  output logic [7:0] iack_vector, // vector returned on acknowledge
  output logic iack_autovector, // autovector request, never raised here
  output logic [2:0] wd_irq_level, // interrupt level to core, zero when none
  output logic soft_reset, // soft reset pulse to all modules but clock synth
  output logic irq // summary interrupt from status and mask
);
  import wdsv_pkg::*;

  logic [7:0] control_reg;
  logic [7:0] vector_reg;
  logic [ST_WIDTH-1:0] status_reg;
  logic [ST_WIDTH-1:0] mask_reg;
  logic timeout_pending_flag;
  logic [27:0] count_reg;
  logic [27:0] count_next;
  wdsv_key_t key_reg;
  logic soft_reset_reg;

  // axi write channel holding
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  logic wr_fire;
  logic wr_hit_ctl;
  logic wr_hit_vec;
  logic wr_hit_svc;
  logic wr_hit_sts;
  logic wr_hit_msk;
  logic wr_known;
  logic lane0;
  logic [7:0] wbyte;
  logic service_done;
  logic bad_key;
  logic timeout_evt;
  logic iack_hit;
  logic [27:0] period;
  logic [1:0] delay_code;

  wdsv_tick_if tk ();

  wdsv_prescaler #(
    .DIV(PRESCALE_DIV)
  ) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .tk(tk)
  );

  // decode used by both write and read paths
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : is_reg

  // write address/data accepted in either order, one write at a time
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // address decode; registers hold their data in byte lane 0
  always_comb begin
    wr_hit_ctl = 1'b0;
    wr_hit_vec = 1'b0;
    wr_hit_svc = 1'b0;
    wr_hit_sts = 1'b0;
    wr_hit_msk = 1'b0;
    if (is_reg({awaddr_reg[7:2], 2'b00}, OFF_CONTROL)) begin
      wr_hit_ctl = wr_fire;
    end else if (is_reg({awaddr_reg[7:2], 2'b00}, OFF_VECTOR)) begin
      wr_hit_vec = wr_fire;
    end else if (is_reg({awaddr_reg[7:2], 2'b00}, OFF_SERVICE)) begin
      wr_hit_svc = wr_fire;
    end else if (is_reg({awaddr_reg[7:2], 2'b00}, OFF_STATUS)) begin
      wr_hit_sts = wr_fire;
    end else if (is_reg({awaddr_reg[7:2], 2'b00}, OFF_MASK)) begin
      wr_hit_msk = wr_fire;
    end
  end
  assign wr_known = is_reg({awaddr_reg[7:2], 2'b00}, OFF_CONTROL) || is_reg({awaddr_reg[7:2], 2'b00}, OFF_VECTOR)
    || is_reg({awaddr_reg[7:2], 2'b00}, OFF_SERVICE) || is_reg({awaddr_reg[7:2], 2'b00}, OFF_STATUS)
    || is_reg({awaddr_reg[7:2], 2'b00}, OFF_MASK) || is_reg({awaddr_reg[7:2], 2'b00}, OFF_COUNT);
  assign lane0 = wstrb_reg[0];
  assign wbyte = wdata_reg[7:0];

  // write response: okay for mapped, slverr for unmapped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // control register: locked while timeout pending; reset disabled, shortest period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_reg <= CONTROL_RESET; // [R10]
    end else if (wr_hit_ctl && lane0 && !timeout_pending_flag) begin // [R11]
      control_reg <= {wbyte[7:3], 3'b000};
    end
  end

  // vector register, loaded with 0x0F by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_reg <= VECTOR_RESET; // [R2]
    end else if (wr_hit_vec && lane0) begin
      vector_reg <= wbyte;
    end
  end

  // service sequence: 0x55 arms, other writes and accesses in between leave it armed
  assign service_done = wr_hit_svc && lane0 && wbyte == KEY_SECOND && key_reg == WDSV_ARMED; // [R4]
  assign bad_key = wr_hit_svc && lane0 && wbyte != KEY_FIRST && !service_done; // [R12]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_reg <= WDSV_IDLE;
    end else begin
      case (key_reg)
        WDSV_IDLE: begin
          if (wr_hit_svc && lane0 && wbyte == KEY_FIRST) begin
            key_reg <= WDSV_ARMED;
          end
        end
        WDSV_ARMED: begin
          // repeated 0x55 and other values keep it armed; only 0xAA completes
          if (service_done) begin // [R5]
            key_reg <= WDSV_IDLE;
          end
        end
        default: key_reg <= WDSV_IDLE;
      endcase
    end
  end

  // timeout period: 2^(9+2*code) ticks of the enable
  // a new delay or prescale is compared against the running count, so software
  // should service right after changing them or the first period may be short
  assign delay_code = control_reg[CTL_DELAY_LSB+1:CTL_DELAY_LSB];
  assign period = 28'(28'd1 << (DELAY_EXP_BASE + DELAY_EXP_STEP * int'(delay_code))); // [R8]
  assign tk.prescale = control_reg[CTL_PRESCALE_BIT]; // [R8]
  assign tk.clear = service_done;

  // countdown counts up in ticks; a service restarts it, disable freezes it
  always_comb begin
    count_next = count_reg;
    if (service_done) begin
      count_next = 28'd0; // [R4]
    end else if (control_reg[CTL_ENABLE_BIT] && tk.tick) begin
      count_next = (count_reg >= period - 28'd1) ? 28'd0 : count_reg + 28'd1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 28'd0;
    end else begin
      count_reg <= count_next;
    end
  end
  assign timeout_evt = !service_done && control_reg[CTL_ENABLE_BIT] && tk.tick && count_reg >= period - 28'd1;

  // acknowledge of the watchdog level while pending claims the cycle
  assign iack_hit = iack_valid && timeout_pending_flag && iack_level == irq_level_cfg;

  // pending flag: set by timeout in interrupt mode, cleared only by acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_pending_flag <= 1'b0;
    end else if (timeout_evt && !control_reg[CTL_SELECT_BIT]) begin // [R9]
      timeout_pending_flag <= 1'b1; // set wins over acknowledge
    end else if (iack_hit) begin
      timeout_pending_flag <= 1'b0; // [R7]
    end
    // service writes never touch the flag [R6]
  end
  assign wd_irq_level = timeout_pending_flag ? irq_level_cfg : 3'd0; // [R9]

  // soft reset pulse in reset-select mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= timeout_evt && control_reg[CTL_SELECT_BIT]; // [R9]
    end
  end
  assign soft_reset = soft_reset_reg;

  // acknowledge answer: always the programmed vector, autovector never
  assign iack_claim = iack_hit; // [R1]
  assign iack_vector = vector_reg; // [R1]
  assign iack_autovector = 1'b0; // [R3]

  // sticky status: timeout, service done, bad key; write one clears, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
    end else begin
      for (int i = 0; i < ST_WIDTH; i++) begin
        if (wr_hit_sts && lane0 && wbyte[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
      if (timeout_evt) begin
        status_reg[ST_TIMEOUT_BIT] <= 1'b1;
      end
      if (service_done) begin
        status_reg[ST_SERVICE_BIT] <= 1'b1;
      end
      if (bad_key) begin
        status_reg[ST_BADKEY_BIT] <= 1'b1;
      end
    end
  end

  // interrupt mask, same layout as the status bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= MASK_RESET;
    end else if (wr_hit_msk && lane0) begin
      mask_reg <= wbyte[ST_WIDTH-1:0];
    end
  end
  assign irq = |(status_reg & mask_reg);

  // read channel: one read at a time, data registered
  assign s_axi_arready = !rvalid_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      // service register is write-only and reads zero
      if (is_reg({s_axi_araddr[7:2], 2'b00}, OFF_CONTROL)) begin
        rdata_reg <= {24'h00_0000, control_reg}; // [R11]
      end else if (is_reg({s_axi_araddr[7:2], 2'b00}, OFF_VECTOR)) begin
        rdata_reg <= {24'h00_0000, vector_reg};
      end else if (is_reg({s_axi_araddr[7:2], 2'b00}, OFF_SERVICE)) begin
        rdata_reg <= 32'h0000_0000;
      end else if (is_reg({s_axi_araddr[7:2], 2'b00}, OFF_STATUS)) begin
        rdata_reg <= {28'h000_0000, timeout_pending_flag, status_reg};
      end else if (is_reg({s_axi_araddr[7:2], 2'b00}, OFF_MASK)) begin
        rdata_reg <= {29'h0000_0000, mask_reg};
      end else if (is_reg({s_axi_araddr[7:2], 2'b00}, OFF_COUNT)) begin
        rdata_reg <= {4'h0, count_reg};
      end else begin
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

endmodule : wdsv_top
`default_nettype wire
